/* core/hdr_bar_pkg.sv */
package hdr_bar_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_HEADER_WORD = 8'h0c;
	localparam logic [7:0] OFF_MEM0_BAR = 8'h10;
	localparam logic [7:0] OFF_MEM0_SETUP = 8'h9c;
	localparam logic [7:0] OFF_MEM0_XLAT = 8'h98;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int LAT_LSB = 8;
	localparam int HDR_CFG_LSB = 16;
	localparam int SINGLE_FN_BIT = 23;
	localparam int BASE_LSB = 12;
	localparam logic [7:0] LAT_RST_FWD = 8'h00;
	localparam logic [7:0] LAT_RST_REV_PCI = 8'h00;
	localparam logic [7:0] LAT_RST_REV_PCIX = 8'h40;
	localparam logic [6:0] HDR_CFG_RST = 7'h00;
	localparam logic [1:0] ADDR_TYPE_32 = 2'h0;
	localparam logic [19:0] BASE_RST = 20'h0_0000;
	localparam logic [19:0] SETUP_RST = 20'h0_0000;
	localparam logic [19:0] XLAT_RST = 20'h0_0000;
	// Edges after reset release until the synchronised straps are settled.
	localparam logic [1:0] INIT_EDGES = 2'h3;
	// 4KB minimum (bits 31:12 all writable) up to 2GB (only bit 31 writable).
	localparam logic [19:0] SIZE_LEGAL_MASK = 20'h8_0000;

	typedef struct packed
	{
		logic valid;
		logic [31:0] addr;
	} mem_req_s;

	typedef struct packed
	{
		logic csr_hit;
		logic fwd_hit;
		logic [31:0] fwd_addr;
	} mem_dec_s;

endpackage : hdr_bar_pkg

/* core/primary_header_bar0_regs.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - Latency timer bits 15:8; forward bridge read-only, reset 00h.
// - Reverse bridge latency timer writable; resets 00h conventional, 40h PCI-X.
// - Header config bits 22:16 read-only zero; bits 31:24 read zero.
// - Bit 23 reads 0, single-function device.
// - Memory-0 address type bits 2:1 read 00, 32-bit decode.
// - Bit 0 and bit 3 read 0; bits 11:4 read zero.
// - Window base in bits 31:12, reset zero, sized by setup register.
// - Window size ranges from 4KB up to 2GB.
// - Lowest 4KB of the window decodes to own control registers.
// - Accesses above the first 4KB are forwarded downstream.
// - Forwarded address built from the translated base register.
// - Base bit writable only where setup bits are 1 from bit 31 down to it, else reads zero.
module primary_header_bar0_regs
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_reverse,
	input wire logic i_pcix,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire hdr_bar_pkg::mem_req_s i_mem,
	output hdr_bar_pkg::mem_dec_s o_dec
);
	import hdr_bar_pkg::*;

	// ----------------------------------------------------------------
	// Strap synchronisers
	// ----------------------------------------------------------------
	// Role and bus-mode straps come from pins, so they pass two flops.
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	logic [1:0] next_strap_meta;
	logic [1:0] next_strap_sync;
	logic rev;
	logic pcix;

	always_comb
	begin
		next_strap_meta = {i_reverse, i_pcix};
		next_strap_sync = strap_meta;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			strap_meta <= 2'h0;
			strap_sync <= 2'h0;
		end
		else if (i_ce)
		begin
			strap_meta <= next_strap_meta;
			strap_sync <= next_strap_sync;
		end
	end

	assign rev = strap_sync[1];
	assign pcix = strap_sync[0];

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] latency;
	logic [19:0] base;
	logic [19:0] setup;
	logic [19:0] xlat;
	logic [1:0] init_cnt;
	logic init_done;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [7:0] next_latency;
	logic [19:0] next_base;
	logic [19:0] next_setup;
	logic [19:0] next_xlat;
	logic [1:0] next_init_cnt;
	logic next_pready;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic access;
	logic wr;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFF_HEADER_WORD) || (a == OFF_MEM0_BAR)
			|| (a == OFF_MEM0_SETUP) || (a == OFF_MEM0_XLAT);
	endfunction : mapped

	// Setup masks are legal only as a contiguous run of ones from bit 31.
	function automatic logic [19:0] legal_mask(input logic [19:0] s);
		logic [19:0] m;
		m = 20'h0_0000;
		for (int i = 19; i >= 0; i--)
		begin
			if (i == 19)
				m[i] = s[i];
			else
				m[i] = s[i] & m[i + 1];
		end
		legal_mask = m;
	endfunction : legal_mask

	logic [19:0] wmask;
	assign wmask = legal_mask(setup);

	// A wait state every access: a simple one-cycle answer after the setup phase.
	assign access = i_psel && i_penable && !pready;
	assign wr = access && i_pwrite;
	assign init_done = (init_cnt == INIT_EDGES);

	always_comb
	begin
		next_latency = latency;
		next_base = base;
		next_setup = setup;
		next_xlat = xlat;
		next_init_cnt = init_done ? init_cnt : init_cnt + 2'h1;
		next_pready = access;
		next_prdata = 32'h0000_0000;
		next_pslverr = access && !mapped(i_paddr);
		// Latency reset value is reloaded until the strap synchronisers have settled.
		// Loading only once would catch the synchronisers' reset value instead.
		if (!init_done)
		begin
			if (rev && pcix)
				next_latency = LAT_RST_REV_PCIX;
			else if (rev)
				next_latency = LAT_RST_REV_PCI;
			else
				next_latency = LAT_RST_FWD;
		end
		if (wr)
		begin
			case (i_paddr)
				OFF_HEADER_WORD:
				begin
					if (rev)
						next_latency = i_pwdata[LAT_LSB +: 8];
				end
				OFF_MEM0_BAR:
				begin
					next_base = i_pwdata[31:BASE_LSB] & wmask;
				end
				OFF_MEM0_SETUP:
				begin
					next_setup = i_pwdata[31:BASE_LSB];
					next_base = base & legal_mask(i_pwdata[31:BASE_LSB]);
				end
				OFF_MEM0_XLAT:
				begin
					next_xlat = i_pwdata[31:BASE_LSB];
				end
				default:
				begin
					next_base = base;
				end
			endcase
		end
		if (access && !i_pwrite)
		begin
			case (i_paddr)
				OFF_HEADER_WORD:
					next_prdata = {8'h00, 1'b0, HDR_CFG_RST, latency, 8'h00};
				OFF_MEM0_BAR:
					next_prdata = {base & wmask, 8'h00, 1'b0, ADDR_TYPE_32, 1'b0};
				OFF_MEM0_SETUP:
					next_prdata = {setup, 12'h000};
				OFF_MEM0_XLAT:
					next_prdata = {xlat, 12'h000};
				default:
					next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			latency <= LAT_RST_FWD;
			base <= BASE_RST;
			setup <= SETUP_RST;
			xlat <= XLAT_RST;
			init_cnt <= 2'h0;
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (i_ce)
		begin
			latency <= next_latency;
			base <= next_base;
			setup <= next_setup;
			xlat <= next_xlat;
			init_cnt <= next_init_cnt;
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	assign o_pready = pready;
	assign o_prdata = prdata;
	assign o_pslverr = pslverr;

	// ----------------------------------------------------------------
	// Window decode
	// ----------------------------------------------------------------
	// Registered decode: the answer trails the request by one cycle.
	mem_dec_s dec;
	mem_dec_s next_dec;
	logic hit;
	logic in_first_4k;

	always_comb
	begin
		hit = (wmask != 20'h0_0000)
			&& ((i_mem.addr[31:BASE_LSB] & wmask) == (base & wmask));
		in_first_4k = ((i_mem.addr[31:BASE_LSB] & ~wmask) == 20'h0_0000);
		next_dec.csr_hit = i_mem.valid && hit && in_first_4k;
		next_dec.fwd_hit = i_mem.valid && hit && !in_first_4k;
		next_dec.fwd_addr = {xlat & wmask, 12'h000}
			| {i_mem.addr[31:BASE_LSB] & ~wmask, i_mem.addr[BASE_LSB - 1:0]};
		if (!(i_mem.valid && hit && !in_first_4k))
			next_dec.fwd_addr = 32'h0000_0000;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			dec <= '0;
		else if (i_ce)
			dec <= next_dec;
	end

	assign o_dec = dec;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_FWD_LAT_RO:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && init_done && !rev) |=> (latency == $past(latency)))
	else $error("Latency timer changed in forward role.");

	AST_REV_LAT_WR:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && init_done && rev && wr && i_paddr == OFF_HEADER_WORD)
		|=> (latency == $past(i_pwdata[15:8])))
	else $error("Reverse latency write not stored.");

	AST_HDR_READ:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && access && !i_pwrite && i_paddr == OFF_HEADER_WORD)
		|=> (o_prdata[31:16] == 16'h0000 && o_pready))
	else $error("Header word upper bits not zero.");

	AST_SINGLE_FN:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && access && !i_pwrite && i_paddr == OFF_HEADER_WORD)
		|=> (o_prdata[SINGLE_FN_BIT] == 1'b0))
	else $error("Single-function bit set.");

	AST_BAR_LOW:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && access && !i_pwrite && i_paddr == OFF_MEM0_BAR)
		|=> (o_prdata[11:0] == 12'h000))
	else $error("BAR low bits not zero.");

	AST_BAR_MASK:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(base & ~wmask) == 20'h0_0000)
	else $error("Base bit set outside writable mask.");

	AST_CSR_HIT:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && i_mem.valid && hit && in_first_4k) |=> (o_dec.csr_hit && !o_dec.fwd_hit))
	else $error("First 4KB not decoded to CSRs.");

	AST_FWD_HIT:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && i_mem.valid && hit && !in_first_4k)
		|=> (o_dec.fwd_hit && o_dec.fwd_addr[11:0] == $past(i_mem.addr[11:0])))
	else $error("Upper window not forwarded.");

	AST_PREADY_PULSE:
	assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_pready |=> !o_pready)
	else $error("Ready held longer than one cycle.");

endmodule : primary_header_bar0_regs

/* testbench/host_apb_model.sv */
`timescale 1ns/10ps
module host_apb_model
(
	input wire logic i_mclk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata
);
	int hung = 0;
	initial
	begin
		o_psel = 1'h0;
		o_penable = 1'h0;
		o_pwrite = 1'h0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0000_0000;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge i_mclk);
		o_psel <= 1'h1;
		o_penable <= 1'h0;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_mclk);
		o_penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (i_pready !== 1'h1 && n < 50);
		if (i_pready !== 1'h1)
			hung++;
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'h0;
		o_penable <= 1'h0;
		// Stale write data is inverted so a slave that latches late sees garbage.
		o_pwdata <= ~d;
	endtask : xfer
endmodule : host_apb_model

/* testbench/primary_header_bar0_regs_bench.sv */
`timescale 1ns/10ps
module primary_header_bar0_regs_bench;
	import hdr_bar_pkg::*;
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic reverse = 1'h0;
	logic pcix = 1'h0;
	logic ce = 1'h1;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [7:0] lat;
	logic [31:0] pwdata, prdata, rd;
	mem_req_s mem = '{1'h0, 32'h0000_0000};
	mem_dec_s dec;
	int errors = 0;
	int checks = 0;
	always #5 mclk = ~mclk;
	primary_header_bar0_regs uut
	(
		.i_mclk(mclk),
		.i_arst_n(arst_n),
		.i_ce(ce),
		.i_reverse(reverse),
		.i_pcix(pcix),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_pready(pready),
		.o_prdata(prdata),
		.o_pslverr(pslverr),
		.i_mem(mem),
		.o_dec(dec)
	);
	host_apb_model host
	(
		.i_mclk(mclk),
		.i_pready(pready),
		.i_prdata(prdata),
		.i_pslverr(pslverr),
		.o_psel(psel),
		.o_penable(penable),
		.o_pwrite(pwrite),
		.o_paddr(paddr),
		.o_pwdata(pwdata)
	);
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task rst(input logic rev, input logic px);
		arst_n <= 1'h0;
		reverse <= rev;
		pcix <= px;
		repeat (20) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (4) @(posedge mclk);
	endtask : rst
	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'h1, a, d, rd, er);
		if (host.hung != 0)
			final_report;
	endtask : wr
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
		input logic ee = 1'h0);
		host.xfer(1'h0, a, 32'h0000_0000, rd, er);
		if (host.hung != 0)
			final_report;
		chk(nm, rd, exp);
		chk("pslverr", {31'h0000_0000, er}, {31'h0000_0000, ee});
	endtask : rdc
	task dchk(input logic [31:0] a, input logic c, input logic f, input logic [31:0] fa);
		@(posedge mclk);
		mem <= '{1'h1, a};
		@(posedge mclk);
		mem <= '{1'h0, 32'h0000_0000};
		#1;
		chk("hits", {30'h0000_0000, dec.csr_hit, dec.fwd_hit}, {30'h0000_0000, c, f});
		if (f)
			chk("fwd_addr", dec.fwd_addr, fa);
	endtask : dchk
	task final_report;
		errors += host.hung;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		for (int m = 0; m < 3; m++)
		begin
			lat = (m == 2) ? 8'h40 : 8'h00;
			rst(m > 0, m == 2);
			rdc("hdr_rst", OFF_HEADER_WORD, {16'h0000, lat, 8'h00});
			wr(OFF_HEADER_WORD, 32'hffff_ffff);
			lat = (m > 0) ? 8'hff : 8'h00;
			rdc("hdr_wr", OFF_HEADER_WORD, {16'h0000, lat, 8'h00});
		end
		rdc("bar_rst", OFF_MEM0_BAR, 32'h0000_0000);
		wr(OFF_MEM0_BAR, 32'hffff_ffff);
		rdc("bar_nomask", OFF_MEM0_BAR, 32'h0000_0000);
		dchk(32'h0000_0010, 1'h0, 1'h0, 32'h0000_0000);
		wr(OFF_MEM0_SETUP, 32'hffff_e000);
		wr(OFF_MEM0_BAR, 32'hffff_ffff);
		rdc("bar_8k", OFF_MEM0_BAR, 32'hffff_e000);
		wr(OFF_MEM0_XLAT, 32'h1234_4000);
		wr(OFF_MEM0_BAR, 32'h8000_0000);
		dchk(32'h8000_0ff0, 1'h1, 1'h0, 32'h0000_0000);
		dchk(32'h8000_1020, 1'h0, 1'h1, 32'h1234_5020);
		dchk(32'h8000_2000, 1'h0, 1'h0, 32'h0000_0000);
		wr(OFF_MEM0_SETUP, 32'hffff_f000);
		wr(OFF_MEM0_BAR, 32'h9000_1000);
		dchk(32'h9000_1ffc, 1'h1, 1'h0, 32'h0000_0000);
		dchk(32'h9000_2000, 1'h0, 1'h0, 32'h0000_0000);
		wr(OFF_MEM0_SETUP, 32'h8000_0000);
		wr(OFF_MEM0_BAR, 32'hffff_ffff);
		rdc("bar_2g", OFF_MEM0_BAR, 32'h8000_0000);
		dchk(32'hc000_0000, 1'h0, 1'h1, 32'h4000_0000);
		dchk(32'h4000_0000, 1'h0, 1'h0, 32'h0000_0000);
		// With the clock enable low the decode must hold its last answer.
		@(posedge mclk);
		ce <= 1'h0;
		mem <= '{1'h1, 32'hc000_0000};
		repeat (2) @(posedge mclk);
		#1;
		chk("ce_frozen", {31'h0000_0000, dec.fwd_hit}, 32'h0000_0000);
		@(posedge mclk);
		ce <= 1'h1;
		@(posedge mclk);
		mem <= '{1'h0, 32'h0000_0000};
		#1;
		chk("ce_run", {31'h0000_0000, dec.fwd_hit}, 32'h0000_0001);
		rdc("unmapped", 8'h40, 32'h0000_0000, 1'h1);
		final_report;
	end
endmodule : primary_header_bar0_regs_bench
